// >>> inc/uep_pkg.sv
package uep_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned ADDR_W        = 11;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned WORDS         = 2048;

  // Times in nanoseconds, as printed.
  localparam int unsigned PULSE_MIN_NS  = 100_000;
  localparam int unsigned PULSE_MAX_NS  = 1_000_000;
  localparam int unsigned TOTAL_MIN_NS  = 100_000_000;
  localparam int unsigned SETUP_NS      = 10_000;
  localparam int unsigned HOLD_NS       = 1_000;
  localparam int unsigned EHOLD_NS      = 500;
  localparam int unsigned READ_DLY_NS   = 10_000;
  localparam int unsigned LOOPS_MIN     = 100;
  localparam int unsigned LOOPS_MAX     = 1000;
  localparam int unsigned NS_PER_S      = 1_000_000_000;

  // Least times round up to whole cycles.
  localparam int unsigned SETUP_CYC =
    (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HOLD_CYC =
    (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned EHOLD_CYC =
    (EHOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned READ_DLY_CYC =
    (READ_DLY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_MAX_CYC =
    (PULSE_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;

  localparam int unsigned CNT_W  = 16;
  localparam int unsigned LOOP_W = 10;

  localparam logic [ADDR_W-1:0] ADDR_LAST  = 11'h7FF;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 11'h000;
  localparam logic [DATA_W-1:0] ERASED     = 8'hFF;

  typedef enum logic [2:0] {
    UEP_IDLE  = 3'b000,
    UEP_ENTER = 3'b001,
    UEP_FETCH = 3'b011,
    UEP_SETUP = 3'b010,
    UEP_PULSE = 3'b110,
    UEP_HOLD  = 3'b111,
    UEP_EXIT  = 3'b101,
    UEP_READ  = 3'b100
  } uep_state_e;

  // Pins toward the memory.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              progEnable;
    logic              progPulse;
    logic [DATA_W-1:0] byteOut;
    logic              byteOe;
  } uep_pins_s;

endpackage : uep_pkg

// >>> logic/uep_timer.sv
`timescale 1ns/1ps
`default_nettype none
module uep_timer
  import uep_pkg::*;
(
  // Clock and reset.
  input  wire  logic             sys_clk,
  input  wire  logic             reset,
  // Control.
  input  wire  logic             load,
  input  wire  logic [CNT_W-1:0] count,
  // Status.
  output logic                   done
);

  logic [CNT_W-1:0] remain_q;

  // Done is high when the loaded count has fully expired.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      remain_q <= '0;
    end else if (load) begin
      remain_q <= count;
    end else if (remain_q != '0) begin
      remain_q <= remain_q - 1'b1;
    end
  end

  // Done ignores load, so a caller may reload on done without a loop.
  assign done = (remain_q == '0);

endmodule : uep_timer
`default_nettype wire

// >>> logic/uep_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module uep_programmer
  import uep_pkg::*;
(
  // Clock and reset.
  input  wire  logic              sys_clk,
  input  wire  logic              reset,
  // Job control.
  input  wire  logic              start,
  input  wire  logic [CNT_W-1:0]  pulseCycles,
  input  wire  logic [LOOP_W-1:0] loopCount,
  // Image source: word for the presented address.
  output logic [ADDR_W-1:0]       imgAddr,
  output logic                    imgReq,
  input  wire  logic [DATA_W-1:0] imgData,
  input  wire  logic              imgCare,
  // Memory pins.
  output logic [ADDR_W-1:0]       memAddr,
  output logic                    progEnable,
  output logic                    progPulse,
  output logic [DATA_W-1:0]       byteOut,
  output logic                    byteOe,
  input  wire  logic [DATA_W-1:0] byteIn,
  // Status.
  output logic                    busy,
  output logic                    done,
  output logic                    badParam,
  output logic [DATA_W-1:0]       readData
);

  uep_state_e        state_q;
  uep_pins_s         pins_q;
  logic [LOOP_W-1:0] loop_q;
  logic [CNT_W-1:0]  width_q;
  logic [LOOP_W-1:0] loops_q;
  logic              busy_q;
  logic              done_q;
  logic              bad_q;
  logic [DATA_W-1:0] rdata_q;
  logic              imgReq_q;
  logic              tLoad;
  logic [CNT_W-1:0]  tCount;
  logic              tDone;
  logic              lastWord;
  assign lastWord = pins_q.addr == ADDR_LAST && loop_q == loops_q - 1'b1;

  default clocking asrtClk @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Width times loop count must reach the total; checked in cycles.
  function automatic logic params_ok(input logic [CNT_W-1:0] w,
                                     input logic [LOOP_W-1:0] n);
    logic [31:0] prod;
    prod = 32'(w) * 32'(n);
    params_ok = (32'(w) >= PULSE_MIN_CYC) && (32'(w) <= PULSE_MAX_CYC)
      && (32'(n) >= LOOPS_MIN) && (32'(n) <= LOOPS_MAX)
      && (prod >= (TOTAL_MIN_NS / NS_PER_S * CLK_HZ)
                  + ((TOTAL_MIN_NS % NS_PER_S) * (CLK_HZ / 1_000_000)
                     / 1000));
  endfunction : params_ok

  uep_timer u_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .load    (tLoad),
    .count   (tCount),
    .done    (tDone)
  );

  // Timer loads on every state entry that needs a wait.
  always_comb begin
    tLoad  = 1'b0;
    tCount = '0;
    case (state_q)
      UEP_IDLE: begin
        tLoad  = start && params_ok(pulseCycles, loopCount);
        tCount = CNT_W'(SETUP_CYC);
      end
      UEP_FETCH: begin
        tLoad  = 1'b1;
        tCount = CNT_W'(SETUP_CYC);
      end
      UEP_SETUP: begin
        tLoad  = tDone;
        tCount = width_q - 1'b1;
      end
      UEP_PULSE: begin
        tLoad  = tDone;
        tCount = CNT_W'(HOLD_CYC);
      end
      UEP_HOLD: begin
        tLoad  = tDone;
        tCount = CNT_W'(READ_DLY_CYC);
      end
      default: begin
        tLoad  = 1'b0;
        tCount = '0;
      end
    endcase
  end

  // Sequencer.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= UEP_IDLE;
    end else begin
      case (state_q)
        UEP_IDLE: begin
          if (start && params_ok(pulseCycles, loopCount)) begin
            state_q <= UEP_ENTER;
          end
        end
        UEP_ENTER: begin
          if (tDone) state_q <= UEP_FETCH;
        end
        UEP_FETCH: state_q <= UEP_SETUP;
        UEP_SETUP: begin
          if (tDone) state_q <= UEP_PULSE;
        end
        UEP_PULSE: begin
          if (tDone) state_q <= UEP_HOLD;
        end
        UEP_HOLD: begin
          if (tDone) begin
            if (lastWord) begin
              state_q <= UEP_EXIT;
            end else begin
              state_q <= UEP_FETCH;
            end
          end
        end
        UEP_EXIT: begin
          if (tDone) state_q <= UEP_READ;
        end
        UEP_READ: state_q <= UEP_IDLE;
        default: state_q <= UEP_IDLE;
      endcase
    end
  end

  // Address and loop counters; the address only moves after a pulse.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pins_q.addr <= ADDR_FIRST;
      loop_q      <= '0;
      width_q     <= '0;
      loops_q     <= '0;
    end else if (state_q == UEP_IDLE) begin
      pins_q.addr <= ADDR_FIRST;
      loop_q      <= '0;
      width_q     <= pulseCycles;
      loops_q     <= loopCount;
    end else if (state_q == UEP_HOLD && tDone && !lastWord) begin
      pins_q.addr <= pins_q.addr + 1'b1;
      if (pins_q.addr == ADDR_LAST) loop_q <= loop_q + 1'b1;
    end
  end

  // Program enable rises on entry, falls before the address may move.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pins_q.progEnable <= 1'b0;
    end else if (state_q == UEP_IDLE && start
                 && params_ok(pulseCycles, loopCount)) begin
      pins_q.progEnable <= 1'b1;
    end else if (state_q == UEP_HOLD && tDone && lastWord) begin
      pins_q.progEnable <= 1'b0;
    end
  end

  // Pulse pin is driven low at all times except during the pulse.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pins_q.progPulse <= 1'b0;
    end else begin
      pins_q.progPulse <= (state_q == UEP_SETUP && tDone)
                          || (state_q == UEP_PULSE && !tDone);
    end
  end

  // Data lines: don't-care words get ones so erased bits stay erased.
  // Previously written words must come back from the image every loop.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pins_q.byteOut <= ERASED;
      pins_q.byteOe  <= 1'b0;
    end else if (state_q == UEP_FETCH) begin
      pins_q.byteOut <= imgCare ? imgData : ERASED;
      pins_q.byteOe  <= 1'b1;
    end else if (state_q == UEP_EXIT || state_q == UEP_IDLE) begin
      pins_q.byteOe  <= 1'b0;
    end
  end

  // Image request and status.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      imgReq_q <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      bad_q    <= 1'b0;
      rdata_q  <= ERASED;
    end else begin
      imgReq_q <= (state_q == UEP_ENTER && tDone)
                  || (state_q == UEP_HOLD && tDone && !lastWord);
      busy_q   <= (state_q != UEP_IDLE) && (state_q != UEP_READ);
      done_q   <= (state_q == UEP_READ);
      if (state_q == UEP_IDLE && start) begin
        bad_q <= !params_ok(pulseCycles, loopCount);
      end
      if (state_q == UEP_READ) rdata_q <= byteIn;
    end
  end

  assign imgAddr    = pins_q.addr;
  assign imgReq     = imgReq_q;
  assign memAddr    = pins_q.addr;
  assign progEnable = pins_q.progEnable;
  assign progPulse  = pins_q.progPulse;
  assign byteOut    = pins_q.byteOut;
  assign byteOe     = pins_q.byteOe;
  assign busy       = busy_q;
  assign done       = done_q;
  assign badParam   = bad_q;
  assign readData   = rdata_q;

  // Pulse width is exactly the programmed count of cycles.
  logic [CNT_W-1:0] pw_q;
  always_ff @(posedge sys_clk) begin
    if (reset) pw_q <= '0;
    else if (progPulse) pw_q <= pw_q + 1'b1;
    else pw_q <= '0;
  end

  AST_PULSE_WIDTH: assert property (
    $fell(progPulse) |-> $past(pw_q) == width_q - 1'b1)
    else $error("pulse width differs from programmed count");

  AST_PULSE_ONLY_IN_MODE: assert property (
    progPulse |-> progEnable && byteOe)
    else $error("pulse outside program mode");

  AST_ADDR_STABLE_PULSE: assert property (
    progPulse |=> $stable(memAddr) || !progPulse)
    else $error("address moved during pulse");

  AST_NEXT_ADDR: assert property (
    $changed(memAddr) && progEnable |-> memAddr == $past(memAddr) + 1'b1)
    else $error("address did not step by one");

  AST_ENABLE_BEFORE_ADDR: assert property (
    $fell(progEnable) |-> !progPulse ##1 $stable(memAddr))
    else $error("address changed with enable fall");

  AST_EXIT_ADDR: assert property (
    $fell(progEnable) |-> memAddr == ADDR_LAST)
    else $error("program mode left before last address");

  AST_PULSE_LOW_IDLE: assert property (
    !progEnable |-> !progPulse)
    else $error("pulse pin not held low");

  AST_DONTCARE_ONES: assert property (
    state_q == UEP_FETCH && !imgCare |=> byteOut == ERASED)
    else $error("don't-care word not all ones");

  AST_SETUP_TIME: assert property (
    $rose(progPulse) |-> $past(byteOe, 8) && $stable(memAddr))
    else $error("pulse without data setup");

  COV_PULSE: cover property ($rose(progPulse));
  COV_WRAP: cover property (
    progEnable && memAddr == ADDR_FIRST && $past(memAddr) == ADDR_LAST);
  COV_DONE: cover property (done);
  COV_BAD: cover property (badParam);

endmodule : uep_programmer
`default_nettype wire

// >>> tb/uep_eprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module uep_eprom_model
  import uep_pkg::*;
(
  // Pins from the programmer.
  input  wire logic [ADDR_W-1:0] memAddr,
  input  wire logic              progEnable,
  input  wire logic              progPulse,
  input  wire logic [DATA_W-1:0] byteOut,
  input  wire logic              byteOe,
  // Toward the programmer.
  output logic [DATA_W-1:0]      byteIn,
  output int                     faults
);
  logic [DATA_W-1:0] cells [WORDS];
  logic [ADDR_W-1:0] lastAddr;
  logic [DATA_W-1:0] lastOut;

  initial begin
    foreach (cells[i]) cells[i] = ERASED;
    faults   = 0;
    lastAddr = ADDR_LAST;
    lastOut  = ERASED;
  end

  // A pulse can only clear bits; nothing electrical sets them again.
  always @(posedge progPulse) begin
    if (progEnable !== 1'b1 || byteOe !== 1'b1) faults++;
    if (memAddr === lastAddr) faults++;
    cells[memAddr] = cells[memAddr] & byteOut;
    lastAddr = memAddr;
  end

  // The enable may only fall once the pulse is over.
  always @(negedge progEnable) begin
    if (progPulse === 1'b1) faults++;
  end

  // While enabled the lines show the inverse so a stale byte never looks valid.
  always @* begin
    if (progEnable !== 1'b1) lastOut = cells[memAddr];
    byteIn = (progEnable === 1'b1) ? ~lastOut : lastOut;
  end
endmodule : uep_eprom_model
`default_nettype wire

// >>> tb/tb_uep_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uep_programmer
  import uep_pkg::*;
;
  logic              sys_clk, reset, start, imgReq, imgCare;
  logic [CNT_W-1:0]  pulseCycles;
  logic [LOOP_W-1:0] loopCount;
  logic [ADDR_W-1:0] imgAddr, memAddr;
  logic [DATA_W-1:0] imgData, byteOut, byteIn, readData;
  logic              progEnable, progPulse, byteOe, busy, done, badParam;
  logic [DATA_W-1:0] imgByte [16];
  logic [15:0]       careMask;
  logic [18:0]       expQ [$];
  logic [18:0]       note;
  int                miscompares, num_checks, pulses, width, faults;
  logic              watch, prevPulse;
  int                badPc [5] = '{3999, 40001, 4000, 4000, 40000};
  int                badLc [5] = '{1000, 100, 99, 999, 1001};

  uep_programmer i_uep_programmer (.sys_clk(sys_clk), .reset(reset),
    .start(start), .pulseCycles(pulseCycles), .loopCount(loopCount),
    .imgAddr(imgAddr), .imgReq(imgReq), .imgData(imgData),
    .imgCare(imgCare), .memAddr(memAddr), .progEnable(progEnable),
    .progPulse(progPulse), .byteOut(byteOut), .byteOe(byteOe),
    .byteIn(byteIn), .busy(busy), .done(done), .badParam(badParam),
    .readData(readData));

  uep_eprom_model i_uep_eprom_model (.memAddr(memAddr),
    .progEnable(progEnable), .progPulse(progPulse), .byteOut(byteOut),
    .byteOe(byteOe), .byteIn(byteIn), .faults(faults));

  assign imgData = imgByte[imgAddr[3:0]];
  assign imgCare = careMask[imgAddr[3:0]];

  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : cycles

  task automatic do_reset;
    reset = 1'b1;
    cycles(2);
    reset = 1'b0;
  endtask : do_reset

  // Watcher: takes the oldest note at each pulse and times its width.
  always @(posedge sys_clk) begin
    if (watch && progPulse && !prevPulse) begin
      pulses++;
      if (expQ.size() == 0) check(32'h1, 32'h0);
      else begin
        note = expQ.pop_front();
        check({memAddr, byteOut}, note);
        check({imgAddr, imgReq}, {note[18:8], 1'b0});
      end
      check({progEnable, byteOe}, 2'h3);
    end
    if (watch && progPulse) width++;
    if (watch && !progPulse && prevPulse) begin
      check(width, pulseCycles);
      width = 0;
    end
    prevPulse = progPulse;
  end

  initial begin
    sys_clk = 1'b0; reset = 1'b1; start = 1'b0; watch = 1'b0;
    prevPulse = 1'b0; pulseCycles = 16'h0FA0; loopCount = 10'h3E8;
    miscompares = 0; num_checks = 0; pulses = 0; width = 0;
    void'($urandom(32'hC112));
    foreach (imgByte[i]) imgByte[i] = 8'($urandom);
    careMask = 16'($urandom);
    cycles(2);
    reset = 1'b0;
    check({progEnable, progPulse, byteOe, busy, done, badParam}, 0);
    check({memAddr, byteOut, readData}, {ADDR_FIRST, ERASED, ERASED});
    // Every out-of-range width or count, and a product short of the total, is turned away.
    for (int k = 0; k < 5; k++) begin
      pulseCycles = 16'(badPc[k]);
      loopCount = 10'(badLc[k]);
      start = 1'b1;
      cycles(1);
      start = 1'b0;
      cycles(2);
      check({badParam, busy, progEnable}, 3'h4);
      do_reset();
    end
    pulseCycles = 16'h0FA0;
    loopCount = 10'h3E8;
    for (int a = 0; a < 8; a++)
      expQ.push_back({11'(a), careMask[a] ? imgByte[a] : ERASED});
    watch = 1'b1;
    start = 1'b1;
    cycles(1);
    start = 1'b0;
    cycles(1);
    check({progEnable, busy}, 2'h3);
    // A second start while busy, even with bad values, is ignored.
    pulseCycles = 16'h0001;
    start = 1'b1;
    cycles(1);
    start = 1'b0;
    cycles(1);
    check(badParam, 1'b0);
    pulseCycles = 16'h0FA0;
    for (int t = 0; t < 45000 && pulses < 8; t++) cycles(1);
    for (int t = 0; t < 50000 && progPulse !== 1'b0; t++) cycles(1);
    check(progPulse, 1'b0);
    check(pulses, 8);
    check(expQ.size(), 0);
    for (int a = 0; a < 8; a++)
      check(i_uep_eprom_model.cells[a],
            careMask[a] ? imgByte[a] : ERASED);
    watch = 1'b0;
    do_reset();
    check({progEnable, progPulse, byteOe, busy}, 4'h0);
    check(faults, 0);
    print_verdict();
  end
endmodule : tb_uep_programmer
`default_nettype wire
